// ==== fsr_params.svh ====
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

`define FSR_TARGET_ADDR   7'h50
`define FSR_RW_READ       1'h1
`define FSR_FLOW_W        12
`define FSR_BYTE_MSB      3'h7
`define FSR_ACK_SLOT      4'h8
`define FSR_READ_BYTES    5
`define FSR_IDX_CKS       3'h0
`define FSR_IDX_HI        3'h1
`define FSR_IDX_LO        3'h2
`define FSR_IDX_HI_RPT    3'h3
`define FSR_IDX_LO_RPT    3'h4
`define FSR_IDX_MAX       3'h7
`define FSR_BUF_DEPTH     2
`define FSR_CLK_PERIOD_NS 8
`define FSR_BIT_FAST_NS   2500
`define FSR_QTR_CYC       (((`FSR_BIT_FAST_NS / 4) + `FSR_CLK_PERIOD_NS - 1) / `FSR_CLK_PERIOD_NS)

`endif

// ==== fsr_pkg.sv ====
package fsr_pkg;

    typedef logic [7:0] fsr_byte_t;

    typedef enum logic [2:0] {
        FSR_T_ADDR,
        FSR_T_ADDR_ACK,
        FSR_T_SEND,
        FSR_T_HOST_ACK,
        FSR_T_IGNORE
    } fsr_tgt_state_t;

    typedef enum logic [1:0] {
        FSR_M_IDLE,
        FSR_M_START,
        FSR_M_XFER,
        FSR_M_STOP
    } fsr_mst_state_t;

endpackage

// ==== fsr_if.sv ====
`timescale 1ns/100ps
`default_nettype none

// Two-wire link; the pull-up is modelled by the wired-AND of both open-drain drivers.
interface fsr_if;
    logic scl;
    logic sda;
    logic m_sda_o;
    logic m_sda_oe;
    logic t_sda_o;
    logic t_sda_oe;

    assign sda = !((m_sda_oe && !m_sda_o) || (t_sda_oe && !t_sda_o));

    modport master (
        output scl,
        output m_sda_o,
        output m_sda_oe,
        input  sda
    );

    modport target (
        input  scl,
        output t_sda_o,
        output t_sda_oe,
        input  sda
    );
endinterface // fsr_if

`default_nettype wire

// ==== fsr_target.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "fsr_params.svh"
module fsr_target #(
    parameter int FLOW_W       = `FSR_FLOW_W,
    parameter int BUF_DEPTH    = `FSR_BUF_DEPTH,
    parameter bit EXTRA_REPEAT = 1'h1
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [FLOW_W-1:0] flow_data,
    input  wire logic              flow_valid,
    output logic                   flow_ready,
    output logic                   frame_active,
    output logic [FLOW_W-1:0]      served_flow,
    fsr_if.target                  link
);

    localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CW = $clog2(BUF_DEPTH + 1);

    if (FLOW_W < 9 || FLOW_W > 16) begin : g_chk_w
        $error("FLOW_W must lie between 9 and 16.");
    end
    if (BUF_DEPTH < 2) begin : g_chk_d
        $error("BUF_DEPTH must be at least 2.");
    end

    // Clock-domain state: pin synchronisers, frame tracking, buffer, snapshot.
    logic [2:0]              scl_sync;
    logic [2:0]              sda_sync;
    logic                    link_rst_n;
    logic [FLOW_W-1:0]       buf_mem [BUF_DEPTH];
    logic [PW-1:0]           wptr;
    logic [PW-1:0]           rptr;
    logic [CW-1:0]           count;
    logic [7:0]              snap_cks;
    logic [2:0]              next_scl_sync;
    logic [2:0]              next_sda_sync;
    logic                    next_active;
    logic                    next_link_rst_n;
    logic [FLOW_W-1:0]       next_mem [BUF_DEPTH];
    logic [PW-1:0]           next_wptr;
    logic [PW-1:0]           next_rptr;
    logic [CW-1:0]           next_count;
    logic                    next_flow_ready;
    logic [FLOW_W-1:0]       next_served;
    logic [7:0]              next_cks;
    logic                    bus_start;
    logic                    bus_stop;
    logic                    scl_fall;
    logic                    push;
    logic                    pop;
    // Link-domain state.
    fsr_pkg::fsr_tgt_state_t tstate;
    fsr_pkg::fsr_tgt_state_t next_tstate;
    logic [2:0]              bitcnt;
    logic [2:0]              next_bitcnt;
    logic [7:0]              shreg;
    logic [7:0]              next_shreg;
    logic [2:0]              byte_idx;
    logic [2:0]              next_byte_idx;
    logic                    next_sda_oe;
    logic [7:0]              tx_cur;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(BUF_DEPTH - 1)) ? '0 : PW'(p + 1'h1);
    endfunction

    function automatic logic [7:0] flow_hi(input logic [FLOW_W-1:0] f);
        logic [15:0] w;
        w = 16'(f);
        return w[15:8];
    endfunction

    function automatic logic [7:0] flow_lo(input logic [FLOW_W-1:0] f);
        return f[7:0];
    endfunction

    function automatic logic [7:0] checksum(input logic [FLOW_W-1:0] f);
        logic [7:0] s;
        s = 8'(flow_hi(f) + flow_lo(f));
        return 8'(8'h00 - (EXTRA_REPEAT ? 8'(s + s) : s));
    endfunction

    // START and STOP are seen only from the synchronised copies of both lines.
    assign bus_start = scl_sync[1] && scl_sync[2] && sda_sync[2] && !sda_sync[1];
    assign bus_stop  = scl_sync[1] && scl_sync[2] && !sda_sync[2] && sda_sync[1];
    assign scl_fall  = scl_sync[2] && !scl_sync[1];
    assign push      = flow_valid && flow_ready;
    assign pop       = (count != '0) && !frame_active;

    always_comb begin
        next_scl_sync   = {scl_sync[1:0], link.scl};
        next_sda_sync   = {sda_sync[1:0], link.sda};
        next_active     = frame_active;
        next_link_rst_n = link_rst_n;
        if (bus_start) begin
            next_active     = 1'h1;
            next_link_rst_n = 1'h0;
        end else if (bus_stop) begin
            next_active     = 1'h0;
            next_link_rst_n = 1'h0;
        end else if (frame_active && scl_fall) begin
            next_link_rst_n = 1'h1;
        end
    end

    // The snapshot changes only between frames, so the link side reads a stable word.
    always_comb begin
        next_mem    = buf_mem;
        next_wptr   = wptr;
        next_rptr   = rptr;
        next_served = served_flow;
        next_cks    = snap_cks;
        if (push) begin
            next_mem[wptr] = flow_data;
            next_wptr      = ptr_inc(wptr);
        end
        if (pop) begin
            next_rptr   = ptr_inc(rptr);
            next_served = buf_mem[rptr];
            next_cks    = checksum(buf_mem[rptr]);
        end
        next_count      = CW'(count + CW'(push) - CW'(pop));
        next_flow_ready = (next_count != CW'(BUF_DEPTH));
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_sync     <= 3'h7;
            sda_sync     <= 3'h7;
            frame_active <= 1'h0;
            link_rst_n   <= 1'h0;
        end else begin
            scl_sync     <= next_scl_sync;
            sda_sync     <= next_sda_sync;
            frame_active <= next_active;
            link_rst_n   <= next_link_rst_n;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            buf_mem     <= '{default: '0};
            wptr        <= '0;
            rptr        <= '0;
            count       <= '0;
            flow_ready  <= 1'h0;
            served_flow <= '0;
            snap_cks    <= 8'h00;
        end else begin
            buf_mem     <= next_mem;
            wptr        <= next_wptr;
            rptr        <= next_rptr;
            count       <= next_count;
            flow_ready  <= next_flow_ready;
            served_flow <= next_served;
            snap_cks    <= next_cks;
        end
    end

    function automatic logic [7:0] tx_byte(input logic [2:0] idx);
        unique case (idx)
            `FSR_IDX_CKS:    return snap_cks;
            `FSR_IDX_HI:     return flow_hi(served_flow);
            `FSR_IDX_LO:     return flow_lo(served_flow);
            `FSR_IDX_HI_RPT: return EXTRA_REPEAT ? flow_hi(served_flow) : 8'h00;
            `FSR_IDX_LO_RPT: return EXTRA_REPEAT ? flow_lo(served_flow) : 8'h00;
            default:         return 8'h00;
        endcase
    endfunction

    // The data line is sampled on the rising link clock; it is stable then by protocol.
    always_comb begin
        next_tstate   = tstate;
        next_bitcnt   = bitcnt;
        next_shreg    = shreg;
        next_byte_idx = byte_idx;
        unique case (tstate)
            fsr_pkg::FSR_T_ADDR: begin
                next_shreg  = {shreg[6:0], link.sda};
                next_bitcnt = 3'(bitcnt + 3'h1);
                if (bitcnt == `FSR_BYTE_MSB) begin
                    if (shreg[6:0] == `FSR_TARGET_ADDR && link.sda == `FSR_RW_READ) begin
                        next_tstate = fsr_pkg::FSR_T_ADDR_ACK;
                    end else begin
                        next_tstate = fsr_pkg::FSR_T_IGNORE;
                    end
                end
            end
            fsr_pkg::FSR_T_ADDR_ACK: begin
                next_tstate   = fsr_pkg::FSR_T_SEND;
                next_bitcnt   = 3'h0;
                next_byte_idx = `FSR_IDX_CKS;
            end
            fsr_pkg::FSR_T_SEND: begin
                next_bitcnt = 3'(bitcnt + 3'h1);
                if (bitcnt == `FSR_BYTE_MSB) begin
                    next_tstate = fsr_pkg::FSR_T_HOST_ACK;
                end
            end
            fsr_pkg::FSR_T_HOST_ACK: begin
                next_bitcnt = 3'h0;
                if (!link.sda) begin
                    next_tstate   = fsr_pkg::FSR_T_SEND;
                    next_byte_idx = (byte_idx == `FSR_IDX_MAX) ? byte_idx : 3'(byte_idx + 3'h1);
                end else begin
                    next_tstate = fsr_pkg::FSR_T_IGNORE;
                end
            end
            fsr_pkg::FSR_T_IGNORE: next_tstate = tstate;
        endcase
    end

    // A START or STOP holds this side in reset, which also frees the data line.
    always_ff @(posedge link.scl or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tstate   <= fsr_pkg::FSR_T_ADDR;
            bitcnt   <= 3'h0;
            shreg    <= 8'h00;
            byte_idx <= 3'h0;
        end else begin
            tstate   <= next_tstate;
            bitcnt   <= next_bitcnt;
            shreg    <= next_shreg;
            byte_idx <= next_byte_idx;
        end
    end

    // The data line changes only on the falling link clock, never while it is high.
    always_comb begin
        tx_cur      = tx_byte(byte_idx);
        next_sda_oe = 1'h0;
        unique case (tstate)
            fsr_pkg::FSR_T_ADDR_ACK: next_sda_oe = 1'h1;
            fsr_pkg::FSR_T_SEND:     next_sda_oe = !tx_cur[3'(`FSR_BYTE_MSB - bitcnt)];
            default:                 next_sda_oe = 1'h0;
        endcase
    end

    always_ff @(negedge link.scl or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link.t_sda_o  <= 1'h0;
            link.t_sda_oe <= 1'h0;
        end else begin
            link.t_sda_o  <= 1'h0;
            link.t_sda_oe <= next_sda_oe;
        end
    end

endmodule // fsr_target
`default_nettype wire

// ==== fsr_master.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "fsr_params.svh"

// Each bit takes four quarters: clock low twice, then high twice.
module fsr_master #(
    parameter int QTR_CYC = `FSR_QTR_CYC,
    parameter int NBYTES  = `FSR_READ_BYTES
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        req_valid,
    output logic             req_ready,
    output logic             rd_done,
    output logic [11:0]      rd_flow,
    output logic             rd_ok,
    output logic             rd_nack,
    fsr_if.master            link
);

    localparam int QW = $clog2(QTR_CYC + 1);

    if (QTR_CYC < 2) begin : g_chk_q
        $error("QTR_CYC must be at least 2.");
    end
    if (NBYTES < 3 || NBYTES > 5) begin : g_chk_n
        $error("NBYTES must lie between 3 and 5.");
    end

    fsr_pkg::fsr_mst_state_t mstate, next_mstate;
    logic [1:0]        sda_sync, next_sda_sync;
    logic [QW-1:0]     qcnt, next_qcnt;
    logic [1:0]        phase, next_phase;
    logic [3:0]        bitn, next_bitn;
    logic [2:0]        byten, next_byten;
    fsr_pkg::fsr_byte_t shreg, next_shreg, cks, next_cks, hi, next_hi, lo, next_lo;
    fsr_pkg::fsr_byte_t sum, next_sum;
    logic              next_scl, next_oe, next_req_ready, next_done, next_ok, next_nack;
    logic [11:0]       next_flow;
    logic              tick;
    logic              last_byte;
    logic [7:0]        addr_byte;

    assign tick      = (qcnt == '0);
    assign last_byte = (byten == 3'(NBYTES));
    assign addr_byte = {`FSR_TARGET_ADDR, `FSR_RW_READ};

    always_comb begin
        next_sda_sync  = {sda_sync[0], link.sda};
        next_mstate    = mstate;
        next_qcnt      = tick ? QW'(QTR_CYC - 1) : QW'(qcnt - 1'h1);
        next_phase     = phase;
        next_bitn      = bitn;
        next_byten     = byten;
        next_shreg     = shreg;
        next_cks       = cks;
        next_hi        = hi;
        next_lo        = lo;
        next_sum       = sum;
        next_scl       = link.scl;
        next_oe        = link.m_sda_oe;
        next_req_ready = 1'h0;
        next_done      = 1'h0;
        next_ok        = rd_ok;
        next_nack      = rd_nack;
        next_flow      = rd_flow;
        unique case (mstate)
            fsr_pkg::FSR_M_IDLE: begin
                next_req_ready = 1'h1;
                next_scl       = 1'h1;
                next_oe        = 1'h0;
                if (req_valid && req_ready) begin
                    next_mstate    = fsr_pkg::FSR_M_START;
                    next_req_ready = 1'h0;
                    next_qcnt      = QW'(QTR_CYC - 1);
                    next_phase     = 2'h0;
                    next_oe        = 1'h1;
                    next_sum       = 8'h00;
                    next_nack      = 1'h0;
                end
            end
            fsr_pkg::FSR_M_START: begin
                if (tick) begin
                    next_phase = 2'(phase + 2'h1);
                    if (phase == 2'h1) begin
                        next_mstate = fsr_pkg::FSR_M_XFER;
                        next_phase  = 2'h0;
                        next_bitn   = 4'h0;
                        next_byten  = 3'h0;
                        next_scl    = 1'h0;
                    end
                end
            end
            fsr_pkg::FSR_M_XFER: begin
                if (tick) begin
                    next_phase = 2'(phase + 2'h1);
                    unique case (phase)
                        2'h0: begin
                            if (byten == 3'h0) begin
                                next_oe = (bitn < `FSR_ACK_SLOT) &&
                                          !addr_byte[3'(`FSR_BYTE_MSB - 3'(bitn))];
                            end else begin
                                next_oe = (bitn == `FSR_ACK_SLOT) && !last_byte;
                            end
                        end
                        2'h1: next_scl = 1'h1;
                        2'h2: next_scl = 1'h1;
                        2'h3: begin
                            next_scl = 1'h0;
                            if (bitn < `FSR_ACK_SLOT) begin
                                next_shreg = {shreg[6:0], sda_sync[1]};
                                next_bitn  = 4'(bitn + 4'h1);
                            end else begin
                                next_bitn = 4'h0;
                                if (byten == 3'h0) begin
                                    if (sda_sync[1]) begin
                                        next_nack   = 1'h1;
                                        next_mstate = fsr_pkg::FSR_M_STOP;
                                    end else begin
                                        next_byten = 3'h1;
                                    end
                                end else begin
                                    if (byten == 3'h1) next_cks = shreg;
                                    if (byten == 3'h2) next_hi = shreg;
                                    if (byten == 3'h3) next_lo = shreg;
                                    if (byten >= 3'h2) next_sum = 8'(sum + shreg);
                                    if (last_byte) begin
                                        next_mstate = fsr_pkg::FSR_M_STOP;
                                    end else begin
                                        next_byten = 3'(byten + 3'h1);
                                    end
                                end
                            end
                        end
                    endcase
                end
            end
            fsr_pkg::FSR_M_STOP: begin
                if (tick) begin
                    next_phase = 2'(phase + 2'h1);
                    unique case (phase)
                        2'h0: next_oe = 1'h1;
                        2'h1: next_scl = 1'h1;
                        2'h2: next_oe = 1'h0;
                        2'h3: begin
                            next_mstate = fsr_pkg::FSR_M_IDLE;
                            next_done   = 1'h1;
                            next_flow   = {hi[3:0], lo};
                            next_ok     = !rd_nack && (8'(cks + sum) == 8'h00);
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mstate        <= fsr_pkg::FSR_M_IDLE;
            sda_sync      <= 2'h3;
            qcnt          <= '0;
            phase         <= 2'h0;
            bitn          <= 4'h0;
            byten         <= 3'h0;
            shreg         <= 8'h00;
            cks           <= 8'h00;
            hi            <= 8'h00;
            lo            <= 8'h00;
            sum           <= 8'h00;
            link.scl      <= 1'h1;
            link.m_sda_o  <= 1'h0;
            link.m_sda_oe <= 1'h0;
            req_ready     <= 1'h0;
            rd_done       <= 1'h0;
            rd_ok         <= 1'h0;
            rd_nack       <= 1'h0;
            rd_flow       <= 12'h000;
        end else begin
            mstate        <= next_mstate;
            sda_sync      <= next_sda_sync;
            qcnt          <= next_qcnt;
            phase         <= next_phase;
            bitn          <= next_bitn;
            byten         <= next_byten;
            shreg         <= next_shreg;
            cks           <= next_cks;
            hi            <= next_hi;
            lo            <= next_lo;
            sum           <= next_sum;
            link.scl      <= next_scl;
            link.m_sda_o  <= 1'h0;
            link.m_sda_oe <= next_oe;
            req_ready     <= next_req_ready;
            rd_done       <= next_done;
            rd_ok         <= next_ok;
            rd_nack       <= next_nack;
            rd_flow       <= next_flow;
        end
    end

endmodule // fsr_master

`default_nettype wire

// ==== fsr_link_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module fsr_link_checker #(
    parameter int NBYTES = 5
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic t_sda_o,
    input wire logic t_sda_oe
);
    localparam logic [7:0] RD_ADDR = 8'hA1;
    localparam logic [7:0] N_RISE  = 8'(9 * (NBYTES + 1) + 1);
    logic       scl_q;
    logic       sda_q;
    logic       rise;
    logic       start;
    logic       stop;
    logic [7:0] rises;
    assign rise  = scl && !scl_q;
    assign start = scl && scl_q && sda_q && !sda;
    assign stop  = scl && scl_q && !sda_q && sda;
    // Counts clock rises since the last start; the stop bit adds one more.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
            rises <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            rises <= start ? 8'h00 : rises + 8'(rise);
        end
    end
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_tgt_low;
        (t_sda_oe && !t_sda_o) [*8];
    endsequence
    sequence s_tgt_free;
        (!t_sda_oe) [*8];
    endsequence
    property p_start_hold; start |-> scl [*8]; endproperty
    a_start_hold: assert property (p_start_hold) else $error("clock fell early");
    property p_addr_bits; rise && rises < 8'h08 |-> sda == RD_ADDR[3'h7 - rises[2:0]]; endproperty
    a_addr_bits: assert property (p_addr_bits) else $error("address bit wrong");
    property p_addr_ack; rise && rises == 8'h08 |-> s_tgt_low; endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
    property p_resp_free; rise && rises > 8'h08 && rises % 8'h09 == 8'h08 |-> !t_sda_oe; endproperty
    a_resp_free: assert property (p_resp_free) else $error("target in master slot");
    property p_tgt_hold; scl && $past(scl) |-> $stable(t_sda_oe) && $stable(t_sda_o); endproperty
    a_tgt_hold: assert property (p_tgt_hold) else $error("data moved, clock high");
    property p_frame_len; stop |-> rises == N_RISE || rises == 8'h0A; endproperty
    a_frame_len: assert property (p_frame_len) else $error("bad bit count");
    property p_stop_free; stop |-> s_tgt_free; endproperty
    a_stop_free: assert property (p_stop_free) else $error("target drives after stop");
    property p_stop_idle; stop |=> (scl && sda) [*4]; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("bus not idle");
    property p_mst_ack;
        rise && rises > 8'h08 && rises % 8'h09 == 8'h08 |->
            !m_sda_o && m_sda_oe == (rises != N_RISE - 8'h02);
    endproperty
    a_mst_ack: assert property (p_mst_ack) else $error("master response wrong");
endmodule // fsr_link_checker
`default_nettype wire

// ==== tb_i2c_flow_data_readout.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_i2c_flow_data_readout;
    logic        clk, nrst, flow_valid, flow_ready, frame_active;
    logic        req_valid, req_ready, rd_done, rd_ok, rd_nack;
    logic [11:0] flow_data, served_flow, rd_flow, w_a, w_b, w_c;
    logic [63:0] wire_sh;
    int          n_mismatch, num_checks, seed, i, acc;
    fsr_if link_if ();
    fsr_target fsr_target_inst (.clk(clk), .nrst(nrst), .flow_data(flow_data),
        .flow_valid(flow_valid), .flow_ready(flow_ready), .frame_active(frame_active),
        .served_flow(served_flow), .link(link_if.target));
    fsr_master #(.QTR_CYC(8), .NBYTES(5)) fsr_master_inst (.clk(clk), .nrst(nrst),
        .req_valid(req_valid), .req_ready(req_ready), .rd_done(rd_done), .rd_flow(rd_flow),
        .rd_ok(rd_ok), .rd_nack(rd_nack), .link(link_if.master));
    fsr_link_checker #(.NBYTES(5)) fsr_link_checker_inst (.clk(clk), .nrst(nrst),
        .scl(link_if.scl), .sda(link_if.sda), .m_sda_o(link_if.m_sda_o),
        .m_sda_oe(link_if.m_sda_oe), .t_sda_o(link_if.t_sda_o), .t_sda_oe(link_if.t_sda_oe));
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    always @(posedge link_if.scl) wire_sh <= {wire_sh[62:0], link_if.sda};
    // Bits seen at clock rises of a full read, ending with the stop bit.
    function automatic logic [63:0] exp_frame(input logic [11:0] w);
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] ck;
        hi = {4'h0, w[11:8]};
        lo = w[7:0];
        ck = 8'h00 - (hi + lo + hi + lo);
        return {9'h000, 8'hA1, 1'h0, ck, 1'h0, hi, 1'h0, lo, 1'h0, hi, 1'h0, lo, 2'h2};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic timeout();
        n_mismatch++;
        $display("BAD t=%0t wait limit reached", $time);
        test_done();
    endtask
    task automatic start_read();
        req_valid = 1'h1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (req_ready !== 1'h1 && i < 20);
        #1 req_valid = 1'h0;
        if (i >= 20) timeout();
    endtask
    task automatic finish_read(input logic [11:0] w);
        i = 0;
        do begin
            @(posedge clk);
            #1 i++;
        end while (rd_done !== 1'h1 && i < 4000);
        if (rd_done !== 1'h1) timeout();
        chk(64'(rd_flow), 64'(w));
        chk(64'({rd_ok, rd_nack}), 64'h2);
        chk({9'h000, wire_sh[54:0]}, exp_frame(w));
    endtask
    initial begin
        seed = 30;
        n_mismatch = 0;
        num_checks = 0;
        nrst = 1'h0;
        flow_valid = 1'h0;
        flow_data = 12'h000;
        req_valid = 1'h0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'h1;
        @(posedge clk);
        #1;
        for (acc = 0; acc < 7; acc++) begin
            w_c = acc == 0 ? 12'h199 : acc == 1 ? 12'h000 : acc == 2 ? 12'hFFF : 12'($random(seed));
            flow_data = w_c;
            flow_valid = 1'h1;
            @(posedge clk);
            #1 flow_valid = 1'h0;
            repeat (3) @(posedge clk);
            #1 chk(64'(served_flow), 64'(w_c));
            start_read();
            finish_read(w_c);
        end
        // Words pushed in mid-frame must wait in the buffer, two at most.
        w_a = 12'($random(seed));
        w_b = 12'($random(seed));
        start_read();
        i = 0;
        do begin
            @(posedge clk);
            #1 i++;
        end while (frame_active !== 1'h1 && i < 20);
        if (frame_active !== 1'h1) timeout();
        flow_valid = 1'h1;
        flow_data = w_a;
        acc = 0;
        for (i = 0; i < 6; i++) begin
            if (flow_ready === 1'h1) acc++;
            @(posedge clk);
            #1 flow_data = acc == 1 ? w_b : 12'h000;
        end
        flow_valid = 1'h0;
        chk(64'(acc), 64'h2);
        chk(64'(served_flow), 64'(w_c));
        finish_read(w_c);
        repeat (6) @(posedge clk);
        #1 chk(64'(served_flow), 64'(w_b));
        start_read();
        finish_read(w_b);
        test_done();
    end
endmodule // tb_i2c_flow_data_readout
`default_nettype wire
